//--- src/cycle_counter.sv
// emulator cycle counter with start/stop address triggers, axi4-lite registers
// assumes core signals are on this clock, one executed address per machine cycle
module cycle_counter #(
  parameter int unsigned ADDR_WIDTH = 15
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // core
  input wire logic emu_run,
  input wire logic emu_go,
  input wire logic emu_break,
  input wire logic exec_valid,
  input wire logic [ADDR_WIDTH-1:0] exec_addr,
  output logic ovf_break_req,
  output logic irq,
  // axi4-lite
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  if (ADDR_WIDTH != cyc_pkg::ADDR_W) begin : g_bad_width
    $error("ADDR_WIDTH must match package");
  end

  // ==========================================================
  // state
  logic [31:0] count;
  logic ovf;
  logic counting;
  logic [1:0] start_mode;
  logic [1:0] stop_mode;
  logic [ADDR_WIDTH-1:0] start_lo, start_hi, stop_lo, stop_hi;
  // staged settings, applied together on apply
  logic [1:0] stg_start_mode, stg_stop_mode;
  logic [ADDR_WIDTH-1:0] stg_start_lo, stg_start_hi, stg_stop_lo, stg_stop_hi;
  logic ovf_break_en;
  logic [cyc_pkg::IRQ_W-1:0] irq_status, irq_mask;
  logic [31:0] load_val;
  logic go_seen;

  logic [31:0] next_count;
  logic next_ovf, next_counting, next_go_seen;
  logic [1:0] next_start_mode, next_stop_mode;
  logic [ADDR_WIDTH-1:0] next_start_lo, next_start_hi, next_stop_lo, next_stop_hi;
  logic [1:0] next_stg_start_mode, next_stg_stop_mode;
  logic [ADDR_WIDTH-1:0] next_stg_start_lo, next_stg_start_hi;
  logic [ADDR_WIDTH-1:0] next_stg_stop_lo, next_stg_stop_hi;
  logic next_ovf_break_en;
  logic [cyc_pkg::IRQ_W-1:0] next_irq_status, next_irq_mask;
  logic [31:0] next_load_val;

  // ==========================================================
  // matchers
  trig_if start_t ();
  trig_if stop_t ();
  assign start_t.mode = start_mode;
  assign start_t.lo = start_lo;
  assign start_t.hi = start_hi;
  assign stop_t.mode = stop_mode;
  assign stop_t.lo = stop_lo;
  assign stop_t.hi = stop_hi;

  trig_match u_start (
    .exec_addr(exec_addr),
    .exec_valid(exec_valid),
    .t(start_t.match)
  );
  trig_match u_stop (
    .exec_addr(exec_addr),
    .exec_valid(exec_valid),
    .t(stop_t.match)
  );

  // ==========================================================
  // axi4-lite slave
  logic aw_held, w_held, ar_done;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic next_aw_held, next_w_held;
  logic [7:0] next_aw_addr_q;
  logic [31:0] next_w_data_q;
  logic [3:0] next_w_strb_q;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_fire;
  logic [31:0] wmask;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr_q = aw_addr_q;
    next_w_data_q = w_data_q;
    next_w_strb_q = w_strb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr_q = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data_q = wdata;
      next_w_strb_q = wstrb;
    end
    wr_fire = aw_held && w_held && !bvalid;
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (aw_addr_q[1:0] == 2'h0 && aw_addr_q <= cyc_pkg::OFF_IRQ_MASK)
        ? cyc_pkg::RESP_OKAY : cyc_pkg::RESP_SLVERR;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  for (genvar i = 0; i < 4; i++) begin : g_wmask
    assign wmask[i*8 +: 8] = w_strb_q[i] ? 8'hff : 8'h00;
  end

  // ==========================================================
  // register file and counter
  logic apply, unset, do_load, neg_load;
  logic start_hit, stop_hit, free_end;
  logic [31:0] wv;

  always_comb begin
    next_start_mode = start_mode;
    next_stop_mode = stop_mode;
    next_start_lo = start_lo;
    next_start_hi = start_hi;
    next_stop_lo = stop_lo;
    next_stop_hi = stop_hi;
    next_stg_start_mode = stg_start_mode;
    next_stg_stop_mode = stg_stop_mode;
    next_stg_start_lo = stg_start_lo;
    next_stg_start_hi = stg_start_hi;
    next_stg_stop_lo = stg_stop_lo;
    next_stg_stop_hi = stg_stop_hi;
    next_ovf_break_en = ovf_break_en;
    next_irq_mask = irq_mask;
    next_load_val = load_val;
    apply = 1'b0;
    unset = 1'b0;
    do_load = 1'b0;
    neg_load = 1'b0;
    wv = w_data_q & wmask;
    if (wr_fire) begin
      unique case (aw_addr_q)
        cyc_pkg::OFF_CTRL: begin
          // every ctrl write rewrites both staged modes
          next_stg_start_mode = w_data_q[cyc_pkg::CTRL_START_MODE +: 2];
          next_stg_stop_mode = w_data_q[cyc_pkg::CTRL_STOP_MODE +: 2];
          next_ovf_break_en = w_data_q[cyc_pkg::CTRL_OVF_BREAK];
          apply = w_data_q[cyc_pkg::CTRL_APPLY];
          unset = w_data_q[cyc_pkg::CTRL_UNSET];
          neg_load = w_data_q[cyc_pkg::CTRL_NEG_LOAD];
        end
        cyc_pkg::OFF_LOAD: begin
          next_load_val = (load_val & ~wmask) | wv;
          do_load = 1'b1;
        end
        cyc_pkg::OFF_START_LO: next_stg_start_lo = wv[ADDR_WIDTH-1:0];
        cyc_pkg::OFF_START_HI: next_stg_start_hi = wv[ADDR_WIDTH-1:0];
        cyc_pkg::OFF_STOP_LO: next_stg_stop_lo = wv[ADDR_WIDTH-1:0];
        cyc_pkg::OFF_STOP_HI: next_stg_stop_hi = wv[ADDR_WIDTH-1:0];
        cyc_pkg::OFF_IRQ_MASK: next_irq_mask = wv[cyc_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // both triggers switch in one cycle
    if (apply) begin
      next_start_mode = stg_start_mode;
      next_stop_mode = stg_stop_mode;
      next_start_lo = stg_start_lo;
      next_start_hi = stg_start_hi;
      next_stop_lo = stg_stop_lo;
      next_stop_hi = stg_stop_hi;
    end
    if (unset) begin
      next_start_mode = cyc_pkg::TRIG_UNSET;
      next_stop_mode = cyc_pkg::TRIG_UNSET;
    end
  end

  always_comb begin
    next_count = count;
    next_ovf = ovf;
    next_counting = counting;
    next_go_seen = go_seen;
    start_hit = 1'b0;
    stop_hit = 1'b0;
    free_end = 1'b0;
    if (emu_go) next_go_seen = 1'b1;
    if (!emu_run) next_go_seen = 1'b0;
    // start: free mode on go, address modes on match; unset never
    if (start_mode == cyc_pkg::TRIG_FREE) start_hit = emu_go;
    else start_hit = start_t.hit;
    if (stop_mode != cyc_pkg::TRIG_FREE) stop_hit = stop_t.hit;
    free_end = !emu_run;
    if (!counting && start_hit && emu_run && !stop_hit && (go_seen || emu_go)) begin
      next_counting = 1'b1;
    end
    // stop cycle itself is not counted
    if (counting && stop_hit) begin
      next_counting = 1'b0;
    end else if (counting && emu_run) begin
      // free stop also counts the break cycle
      if (stop_mode == cyc_pkg::TRIG_FREE || !emu_break || exec_valid) begin
        next_count = count + 32'h0000_0001;
        if (count == cyc_pkg::CNT_MAX) next_ovf = 1'b1;
      end
    end
    if (counting && free_end) next_counting = 1'b0;
    // idle count is held; flag cleared only by load
    if (do_load) begin
      next_count = next_load_val;
      next_ovf = 1'b0;
    end
    if (neg_load) begin
      next_count = cyc_pkg::CNT_MAX - load_val;
      next_ovf = 1'b0;
    end
  end

  always_comb begin
    next_irq_status = irq_status;
    if (wr_fire && aw_addr_q == cyc_pkg::OFF_IRQ_STATUS) begin
      next_irq_status = irq_status & ~wv[cyc_pkg::IRQ_W-1:0];
    end
    // set wins over clear
    if (next_ovf && !ovf) next_irq_status[cyc_pkg::IRQ_OVF] = 1'b1;
    if (next_counting && !counting) next_irq_status[cyc_pkg::IRQ_START] = 1'b1;
    if (!next_counting && counting) next_irq_status[cyc_pkg::IRQ_STOP] = 1'b1;
  end

  always_comb begin
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = cyc_pkg::RESP_OKAY;
      unique case (araddr)
        cyc_pkg::OFF_CTRL: next_rdata = {27'h000_0000, ovf_break_en, stop_mode, start_mode};
        cyc_pkg::OFF_LOAD: next_rdata = load_val;
        cyc_pkg::OFF_COUNT: next_rdata = count;
        cyc_pkg::OFF_START_LO: next_rdata = {17'h0_0000, start_lo};
        cyc_pkg::OFF_START_HI: next_rdata = {17'h0_0000, start_hi};
        cyc_pkg::OFF_STOP_LO: next_rdata = {17'h0_0000, stop_lo};
        cyc_pkg::OFF_STOP_HI: next_rdata = {17'h0_0000, stop_hi};
        cyc_pkg::OFF_STATUS: next_rdata = {30'h0000_0000, counting, ovf};
        cyc_pkg::OFF_IRQ_STATUS: next_rdata = {29'h0000_0000, irq_status};
        cyc_pkg::OFF_IRQ_MASK: next_rdata = {29'h0000_0000, irq_mask};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = cyc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count <= 32'h0000_0000;
      ovf <= 1'b0;
      counting <= 1'b0;
      go_seen <= 1'b0;
      start_mode <= cyc_pkg::TRIG_UNSET;
      stop_mode <= cyc_pkg::TRIG_UNSET;
      start_lo <= '0;
      start_hi <= '0;
      stop_lo <= '0;
      stop_hi <= '0;
      stg_start_mode <= cyc_pkg::TRIG_UNSET;
      stg_stop_mode <= cyc_pkg::TRIG_UNSET;
      stg_start_lo <= '0;
      stg_start_hi <= '0;
      stg_stop_lo <= '0;
      stg_stop_hi <= '0;
      ovf_break_en <= 1'b0;
      irq_status <= '0;
      irq_mask <= '0;
      load_val <= 32'h0000_0000;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
      ovf_break_req <= 1'b0;
      irq <= 1'b0;
      ar_done <= 1'b0;
    end else begin
      count <= next_count;
      ovf <= next_ovf;
      counting <= next_counting;
      go_seen <= next_go_seen;
      start_mode <= next_start_mode;
      stop_mode <= next_stop_mode;
      start_lo <= next_start_lo;
      start_hi <= next_start_hi;
      stop_lo <= next_stop_lo;
      stop_hi <= next_stop_hi;
      stg_start_mode <= next_stg_start_mode;
      stg_stop_mode <= next_stg_stop_mode;
      stg_start_lo <= next_stg_start_lo;
      stg_start_hi <= next_stg_start_hi;
      stg_stop_lo <= next_stg_stop_lo;
      stg_stop_hi <= next_stg_stop_hi;
      ovf_break_en <= next_ovf_break_en;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      load_val <= next_load_val;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr_q <= next_aw_addr_q;
      w_data_q <= next_w_data_q;
      w_strb_q <= next_w_strb_q;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= ar_done ? next_arready : 1'b1;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      ovf_break_req <= next_ovf && ovf_break_en;
      irq <= |(next_irq_status & irq_mask);
      ar_done <= 1'b1;
    end
  end
endmodule : cycle_counter

//--- pkg/cyc_pkg.sv
// package of constants for the emulator cycle counter with start/stop triggers
// assumes an axi4-lite master on the same clock and a core giving one address per cycle
package cyc_pkg;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned CNT_W = 32;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LOAD = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_START_LO = 8'h0c;
  localparam logic [7:0] OFF_START_HI = 8'h10;
  localparam logic [7:0] OFF_STOP_LO = 8'h14;
  localparam logic [7:0] OFF_STOP_HI = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
  // ctrl fields
  localparam int unsigned CTRL_START_MODE = 0;
  localparam int unsigned CTRL_STOP_MODE = 2;
  localparam int unsigned CTRL_OVF_BREAK = 4;
  localparam int unsigned CTRL_APPLY = 8;
  localparam int unsigned CTRL_UNSET = 9;
  localparam int unsigned CTRL_NEG_LOAD = 10;
  // status fields
  localparam int unsigned STAT_OVF = 0;
  localparam int unsigned STAT_COUNTING = 1;
  // irq fields
  localparam int unsigned IRQ_OVF = 0;
  localparam int unsigned IRQ_START = 1;
  localparam int unsigned IRQ_STOP = 2;
  localparam int unsigned IRQ_W = 3;
  localparam logic [31:0] CNT_MAX = 32'hffff_ffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TRIG_UNSET,
    TRIG_SINGLE,
    TRIG_RANGE,
    TRIG_FREE
  } trig_mode_t;
endpackage : cyc_pkg

//--- pkg/trig_if.sv
// interface carrying one trigger's setting from the register file to a matcher
// assumes single clock; the matcher reads mode, lo and hi and drives only hit
interface trig_if;
  logic [1:0] mode;
  logic [cyc_pkg::ADDR_W-1:0] lo;
  logic [cyc_pkg::ADDR_W-1:0] hi;
  logic hit;
  modport cfg (output mode, output lo, output hi, input hit);
  modport match (input mode, input lo, input hi, output hit);
endinterface : trig_if

//--- src/trig_match.sv
// address matcher for one trigger
// assumes the executed address is valid only when exec_valid is high
module trig_match (
  // core side
  input wire logic [cyc_pkg::ADDR_W-1:0] exec_addr,
  input wire logic exec_valid,
  // trigger setting
  trig_if.match t
);
  always_comb begin
    t.hit = 1'b0;
    unique case (t.mode)
      cyc_pkg::TRIG_SINGLE: t.hit = exec_valid && (exec_addr == t.lo);
      cyc_pkg::TRIG_RANGE: t.hit = exec_valid && (exec_addr >= t.lo)
        && (exec_addr <= t.hi);
      default: t.hit = 1'b0;
    endcase
  end
endmodule : trig_match

//--- dv/core_model.sv
// partner model: emulated core stepping through consecutive program addresses
// assumes the bench raises go_req only while busy is low
module core_model (
  // clock
  input wire logic clock,
  // bench control
  input wire logic go_req,
  input wire logic [cyc_pkg::ADDR_W-1:0] base,
  input wire logic [7:0] len,
  output logic busy,
  // core side
  output logic emu_run,
  output logic emu_go,
  output logic emu_break,
  output logic exec_valid,
  output logic [cyc_pkg::ADDR_W-1:0] exec_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // execution sequence
  initial begin
    {busy, emu_run, emu_go, emu_break, exec_valid} = '0;
    exec_addr = '0;
    forever begin
      @(posedge clock);
      if (go_req) begin
        busy <= 1'b1;
        for (int i = 0; i < len; i++) begin
          emu_go <= (i == 0);
          emu_run <= 1'b1;
          exec_valid <= 1'b1;
          exec_addr <= base + i[cyc_pkg::ADDR_W-1:0];
          emu_break <= (i == len - 1);
          @(posedge clock);
        end
        {busy, emu_run, emu_go, emu_break, exec_valid} <= '0;
      end else begin
        // idle bus keeps moving so a stale address never looks settled
        exec_addr <= ~exec_addr;
      end
    end
  end
endmodule : core_model

//--- dv/cycle_counter_checker.sv
// concurrent checks on the cycle counter top-level ports
// assumes the master holds bready high for the whole write
module cycle_counter_checker (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // watched ports
  input wire logic ovf_break_req,
  input wire logic irq,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // assertions
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable({rresp, rdata}))
    else $error("read data dropped early");
  write_answer_a: assert property (awvalid && awready |-> ##[1:8] bvalid)
    else $error("write not answered");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  one_write_a: assert property (bvalid |-> !awready && !wready)
    else $error("new write accepted before response");
  err_data_a: assert property (rvalid && rresp == cyc_pkg::RESP_SLVERR |-> rdata == 32'h0000_0000)
    else $error("refused read carries data");
  ovf_sticky_a: assert property (
    ovf_break_req && !awvalid && !bready |=> ovf_break_req)
    else $error("overflow break dropped without a write");
  reset_quiet_a: assert property (disable iff (1'b0)
    !reset_n |=> !irq && !ovf_break_req && !bvalid && !rvalid)
    else $error("outputs active after reset");
endmodule : cycle_counter_checker

bind cycle_counter cycle_counter_checker cycle_counter_checker_inst (.clock(clock),
  .reset_n(reset_n), .ovf_break_req(ovf_break_req), .irq(irq), .awvalid(awvalid),
  .awready(awready), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready));

//--- dv/cycle_counter_tb.sv
// self-checking bench: axi4-lite master, core model, scoreboard of bus answers
// assumes every handshake is answered within 300 cycles
module cycle_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset_n, go_req, busy, emu_run, emu_go, emu_break, exec_valid, ovf_break_req, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [cyc_pkg::ADDR_W-1:0] exec_addr, base;
  logic [7:0] len, awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_errors = 0;
  int checked = 0;
  cycle_counter #(.ADDR_WIDTH(cyc_pkg::ADDR_W)) cycle_counter_inst (.clock(clock),
    .reset_n(reset_n), .emu_run(emu_run), .emu_go(emu_go), .emu_break(emu_break),
    .exec_valid(exec_valid), .exec_addr(exec_addr), .ovf_break_req(ovf_break_req), .irq(irq),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  core_model core_model_inst (.clock(clock), .go_req(go_req), .base(base), .len(len),
    .busy(busy), .emu_run(emu_run), .emu_go(emu_go), .emu_break(emu_break),
    .exec_valid(exec_valid), .exec_addr(exec_addr));
  // ==========================================
  // checking and closing
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic give_up(input int n);
    if (n >= 300) begin
      n_errors++;
      final_report();
    end
  endtask : give_up
  function automatic logic [33:0] ok(input logic [31:0] d);
    return {cyc_pkg::RESP_OKAY, d};
  endfunction : ok
  always @(posedge clock) begin
    if (rvalid && rready && rq.size() > 0) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready && bq.size() > 0) chk(34'(bresp), 34'(bq.pop_front()));
  end
  // ==========================================
  // bus and core drivers
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = cyc_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge clock);
    bq.push_back(e);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clock);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 300);
    bready <= 1'b0;
    give_up(n);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    n = 0;
    @(posedge clock);
    rq.push_back(e);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clock);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 300);
    rready <= 1'b0;
    give_up(n);
  endtask : rd
  // apply copies what is already staged, so modes are staged by a first write
  task automatic ctl(input int st, input int sp, input int x);
    wr(cyc_pkg::OFF_CTRL, (sp << cyc_pkg::CTRL_STOP_MODE) | st);
    wr(cyc_pkg::OFF_CTRL, x | (sp << cyc_pkg::CTRL_STOP_MODE) | st | (1 << cyc_pkg::CTRL_APPLY));
  endtask : ctl
  task automatic run(input logic [cyc_pkg::ADDR_W-1:0] b, input logic [7:0] l);
    int n;
    n = 0;
    @(posedge clock);
    base <= b;
    len <= l;
    go_req <= 1'b1;
    repeat (2) @(posedge clock);
    go_req <= 1'b0;
    do begin
      @(posedge clock);
      n++;
    end while (busy && n < 300);
    give_up(n);
  endtask : run
  // ==========================================
  // clock and main sequence
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    {reset_n, go_req, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, len, base, wdata} = '0;
    wstrb = 4'hf;
    void'($urandom(32'h6bd5_ce07));
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    v = $urandom;
    wr(cyc_pkg::OFF_LOAD, v);
    rd(cyc_pkg::OFF_COUNT, ok(v));
    wr(8'h30, v, cyc_pkg::RESP_SLVERR);
    rd(8'h31, {cyc_pkg::RESP_SLVERR, 32'h0000_0000});
    ctl(0, 0, 1 << cyc_pkg::CTRL_UNSET);
    run(15'h7000, 8'd20);
    rd(cyc_pkg::OFF_COUNT, ok(v));
    wr(cyc_pkg::OFF_LOAD, 32'h0000_0000);
    ctl(3, 3, 0);
    v = 32'd10 + $urandom_range(30);
    run(15'h7000, v[7:0]);
    rd(cyc_pkg::OFF_COUNT, ok(v - 32'd1));
    rd(cyc_pkg::OFF_COUNT, ok(v - 32'd1));
    wr(cyc_pkg::OFF_LOAD, 32'h0000_0000);
    wr(cyc_pkg::OFF_START_LO, 32'h0000_7105);
    wr(cyc_pkg::OFF_STOP_LO, 32'h0000_710c);
    ctl(1, 1, 0);
    run(15'h7100, 8'd20);
    rd(cyc_pkg::OFF_COUNT, ok(32'd6));
    wr(cyc_pkg::OFF_STOP_LO, 32'h0000_7110);
    wr(cyc_pkg::OFF_STOP_HI, 32'h0000_7120);
    ctl(1, 2, 0);
    run(15'h7100, 8'd20);
    rd(cyc_pkg::OFF_COUNT, ok(32'd16));
    wr(cyc_pkg::OFF_LOAD, 32'h0000_0000);
    wr(cyc_pkg::OFF_START_LO, 32'h0000_7103);
    wr(cyc_pkg::OFF_START_HI, 32'h0000_7108);
    ctl(2, 1, 0);
    run(15'h7100, 8'd20);
    rd(cyc_pkg::OFF_COUNT, ok(32'd12));
    wr(cyc_pkg::OFF_LOAD, 32'd100);
    ctl(3, 3, (1 << cyc_pkg::CTRL_NEG_LOAD) | (1 << cyc_pkg::CTRL_OVF_BREAK));
    rd(cyc_pkg::OFF_COUNT, ok(cyc_pkg::CNT_MAX - 32'd100));
    run(15'h7000, 8'd102);
    rd(cyc_pkg::OFF_COUNT, ok(32'h0000_0000));
    rd(cyc_pkg::OFF_STATUS, ok(32'h0000_0001));
    chk(34'(ovf_break_req), 34'h1);
    chk(34'(irq), 34'h0);
    wr(cyc_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk(34'(irq), 34'h1);
    wr(cyc_pkg::OFF_IRQ_STATUS, 32'h0000_0007);
    repeat (2) @(posedge clock);
    chk(34'(irq), 34'h0);
    wr(cyc_pkg::OFF_LOAD, 32'd5);
    rd(cyc_pkg::OFF_STATUS, ok(32'h0000_0000));
    chk(34'(ovf_break_req), 34'h0);
    @(posedge clock);
    final_report();
  end
endmodule : cycle_counter_tb
